// ==== core/hdlc_fifo_test_access.sv ====
// Four data link FIFOs (two receive, two transmit) with their test access
// registers: pointer observation, pointer clears, test writes, bypass.
// Assumes the register strobes come from logic on ref_clk, one cycle each,
// and that the link side and the host side are already on ref_clk.

// Operation
// - The clock test bit forces all FIFO clocks on, else link control settings rule.
// - Shadow select makes the pointer status registers show shadow pointers.
// - The select field picks rx one, rx two, tx one or tx two for observation.
// - The read pointer status register shows the selected read or shadow read pointer.
// - The write pointer status register shows the selected write or shadow write pointer.
// - A read clear bit holds that FIFO's read pointer at empty (bit 6 tx, bit 3 rx).
// - A write clear bit loads that FIFO's write pointer with its current read pointer, without blocking drains (bit 5 tx, bit 2 rx).
// - With the tx test write bit set, host data goes into the tx FIFO at its write pointer.
// - With the rx test write bit set, host data goes into the rx FIFO at its write pointer.
// - The channel two control register has the same bits acting on the channel two FIFOs.
module hdlc_fifo_test_access #(
    parameter int DW = hft_pkg::DATA_W,
    parameter int AW = hft_pkg::PTR_W
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [hft_pkg::NUM_FIFO-1:0] host_fifo_wr,
    input wire logic [1:0] link_clk_enable,
    output logic [hft_pkg::NUM_FIFO-1:0] fifo_clk_enable,
    input wire logic [hft_pkg::NUM_FIFO-1:0] fill_valid,
    input wire logic [hft_pkg::NUM_FIFO-1:0][DW-1:0] fill_data,
    output logic [hft_pkg::NUM_FIFO-1:0] fill_ready,
    input wire logic [hft_pkg::NUM_FIFO-1:0] drain_req,
    output logic [hft_pkg::NUM_FIFO-1:0] drain_valid,
    output logic [hft_pkg::NUM_FIFO-1:0][DW-1:0] drain_data,
    output logic [hft_pkg::NUM_FIFO-1:0] fifo_empty,
    output logic [hft_pkg::NUM_FIFO-1:0] fifo_full,
    input wire logic [hft_pkg::NUM_FIFO-1:0] msg_mark
);
    import hft_pkg::*;

    // Reset release through two flops
    logic rst_meta_reg;
    logic rst_sync_reg;
    wire rst_n = rst_sync_reg;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Registers
    logic [7:0] test_select_reg;
    logic [7:0] ch1_control_reg;
    logic [7:0] ch2_control_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    wire wr_select = reg_wr && (reg_addr == ADDR_FIFO_TEST_SELECT);
    wire wr_ch1 = reg_wr && (reg_addr == ADDR_CH1_TEST_CONTROL);
    wire wr_ch2 = reg_wr && (reg_addr == ADDR_CH2_TEST_CONTROL);

    // All reset to zero, the neutral setting expected in normal use
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            test_select_reg <= RESET_FIFO_TEST_SELECT;
            ch1_control_reg <= RESET_TEST_CONTROL;
            ch2_control_reg <= RESET_TEST_CONTROL;
        end else begin
            if (wr_select) begin
                test_select_reg <= reg_wdata & MASK_FIFO_TEST_SELECT;
            end
            if (wr_ch1) begin
                ch1_control_reg <= reg_wdata & MASK_TEST_CONTROL;
            end
            if (wr_ch2) begin
                ch2_control_reg <= reg_wdata & MASK_TEST_CONTROL;
            end
        end
    end

    wire clock_test = test_select_reg[BIT_CLOCK_TEST];
    wire shadow_sel = test_select_reg[BIT_SHADOW_SELECT];
    wire [1:0] fifo_sel = test_select_reg[BIT_SELECT_HI:BIT_SELECT_LO];

    // Picks a control bit for FIFO idx: bit 1 of idx is transmit, bit 0 channel two
    function automatic logic ctl_bit(input logic [1:0] idx, input logic [7:0] c1,
                                     input logic [7:0] c2, input int tx_pos, input int rx_pos);
        logic [7:0] c;
        c = idx[0] ? c2 : c1;
        return idx[1] ? c[tx_pos] : c[rx_pos];
    endfunction

    logic [NUM_FIFO-1:0][AW-1:0] rd_ptr_w;
    logic [NUM_FIFO-1:0][AW-1:0] wr_ptr_w;
    logic [NUM_FIFO-1:0][AW-1:0] sh_rd_w;
    logic [NUM_FIFO-1:0][AW-1:0] sh_wr_w;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FIFO; gi++) begin : g_fifo
            localparam logic [1:0] IDX = 2'(gi);
            logic [AW-1:0] rd_ptr_reg;
            logic [AW-1:0] rd_ptr_next;
            logic [AW-1:0] wr_ptr_reg;
            logic [AW-1:0] wr_ptr_next;
            logic [AW-1:0] sh_rd_reg;
            logic [AW-1:0] sh_wr_reg;
            logic drain_valid_reg;
            logic bypass_sel_reg;
            logic [DW-1:0] bypass_data_reg;
            logic [DW-1:0] ram_q;

            wire rd_clr = ctl_bit(IDX, ch1_control_reg, ch2_control_reg,
                                  BIT_TX_READ_CLEAR, BIT_RX_READ_CLEAR);
            wire wr_clr = ctl_bit(IDX, ch1_control_reg, ch2_control_reg,
                                  BIT_TX_WRITE_CLEAR, BIT_RX_WRITE_CLEAR);
            wire test_wr_en = ctl_bit(IDX, ch1_control_reg, ch2_control_reg,
                                      BIT_TX_TEST_WRITE, BIT_RX_TEST_WRITE);
            // Bypass exists only on the receive FIFOs
            wire bypass = !IDX[1] && ctl_bit(IDX, ch1_control_reg, ch2_control_reg,
                                             BIT_RX_BYPASS, BIT_RX_BYPASS);

            wire empty = (rd_ptr_reg == wr_ptr_reg);
            wire full = (AW'(wr_ptr_reg + 1'b1) == rd_ptr_reg);
            // Test write wins over the normal fill source in the same cycle
            wire test_push = test_wr_en && host_fifo_wr[gi] && !full && !wr_clr;
            wire fill_ok = !full && !wr_clr && !test_push;
            wire fill_push = fill_valid[gi] && fill_ok && !bypass;
            wire push = test_push || fill_push;
            wire pop = drain_req[gi] && !empty && !rd_clr && !bypass;
            wire byp_pass = bypass && fill_valid[gi];
            wire [DW-1:0] push_data = test_push ? reg_wdata : fill_data[gi];

            // Both clears together leave both pointers at zero
            assign wr_ptr_next = wr_clr ? (rd_clr ? '0 : rd_ptr_reg) :
                                 push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
            assign rd_ptr_next = rd_clr ? (wr_clr ? '0 : wr_ptr_next) :
                                 pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;

            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    rd_ptr_reg <= '0;
                    wr_ptr_reg <= '0;
                end else begin
                    rd_ptr_reg <= rd_ptr_next;
                    wr_ptr_reg <= wr_ptr_next;
                end
            end

            // Shadow copies taken at message boundaries
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sh_rd_reg <= '0;
                    sh_wr_reg <= '0;
                end else if (msg_mark[gi]) begin
                    sh_rd_reg <= rd_ptr_reg;
                    sh_wr_reg <= wr_ptr_reg;
                end
            end

            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    drain_valid_reg <= 1'b0;
                    bypass_sel_reg <= 1'b0;
                    bypass_data_reg <= '0;
                end else begin
                    drain_valid_reg <= pop || byp_pass;
                    if (pop || byp_pass) begin
                        bypass_sel_reg <= byp_pass;
                    end
                    if (byp_pass) begin
                        bypass_data_reg <= fill_data[gi];
                    end
                end
            end

            hft_fifo_ram #(
                .DW(DW),
                .AW(AW)
            ) u_ram (
                .clk(ref_clk),
                .rst_n(rst_n),
                .we(push),
                .waddr(wr_ptr_reg),
                .wdata(push_data),
                .re(pop),
                .raddr(rd_ptr_reg),
                .rdata(ram_q)
            );

            assign fill_ready[gi] = bypass || fill_ok;
            assign drain_valid[gi] = drain_valid_reg;
            assign drain_data[gi] = bypass_sel_reg ? bypass_data_reg : ram_q;
            assign fifo_empty[gi] = empty;
            assign fifo_full[gi] = full;
            // Channel one link control drives fifos 0 and 2, channel two 1 and 3
            assign fifo_clk_enable[gi] = clock_test || link_clk_enable[gi % 2];
            assign rd_ptr_w[gi] = rd_ptr_reg;
            assign wr_ptr_w[gi] = wr_ptr_reg;
            assign sh_rd_w[gi] = sh_rd_reg;
            assign sh_wr_w[gi] = sh_wr_reg;
        end
    endgenerate

    // Observed pointers
    wire [AW-1:0] obs_rd = shadow_sel ? sh_rd_w[fifo_sel] : rd_ptr_w[fifo_sel];
    wire [AW-1:0] obs_wr = shadow_sel ? sh_wr_w[fifo_sel] : wr_ptr_w[fifo_sel];

    always_comb begin
        unique case (reg_addr)
            ADDR_FIFO_TEST_SELECT: rdata_next = test_select_reg;
            ADDR_READ_PTR_STATUS: rdata_next = 8'(obs_rd);
            ADDR_WRITE_PTR_STATUS: rdata_next = 8'(obs_wr);
            ADDR_CH1_TEST_CONTROL: rdata_next = ch1_control_reg;
            ADDR_CH2_TEST_CONTROL: rdata_next = ch2_control_reg;
            default: rdata_next = UNMAPPED_READ;
        endcase
    end

    // Read data is captured on the strobe and held until the next read
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= UNMAPPED_READ;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
endmodule

// ==== core/hft_fifo_ram.sv ====
// Storage for one data link FIFO: one write port, one registered read port.
// Assumes the caller never reads and writes one address in the same cycle
// expecting the new value; the read returns the old word then.
module hft_fifo_ram #(
    parameter int DW = 8,
    parameter int AW = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Only the read register is reset so the output is defined from reset on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule

// ==== core/hft_pkg.sv ====
// Constants for the data link FIFO test access block.
// Assumes an 8-bit register port with byte offsets as printed.
package hft_pkg;
    localparam int DATA_W = 8;
    localparam int PTR_W = 6;
    localparam int NUM_FIFO = 4;

    localparam logic [7:0] ADDR_FIFO_TEST_SELECT = 8'hBA;
    localparam logic [7:0] ADDR_READ_PTR_STATUS = 8'hBB;
    localparam logic [7:0] ADDR_WRITE_PTR_STATUS = 8'hBC;
    localparam logic [7:0] ADDR_CH1_TEST_CONTROL = 8'hBD;
    localparam logic [7:0] ADDR_CH2_TEST_CONTROL = 8'hBE;

    localparam logic [7:0] RESET_FIFO_TEST_SELECT = 8'h00;
    localparam logic [7:0] RESET_TEST_CONTROL = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Writable bits of each register; the rest read as zero
    localparam logic [7:0] MASK_FIFO_TEST_SELECT = 8'h0F;
    localparam logic [7:0] MASK_TEST_CONTROL = 8'h7F;

    // fifo_test_select fields
    localparam int BIT_CLOCK_TEST = 3;
    localparam int BIT_SHADOW_SELECT = 2;
    localparam int BIT_SELECT_HI = 1;
    localparam int BIT_SELECT_LO = 0;

    // Test control fields, same positions for both channels
    localparam int BIT_TX_READ_CLEAR = 6;
    localparam int BIT_TX_WRITE_CLEAR = 5;
    localparam int BIT_TX_TEST_WRITE = 4;
    localparam int BIT_RX_READ_CLEAR = 3;
    localparam int BIT_RX_WRITE_CLEAR = 2;
    localparam int BIT_RX_TEST_WRITE = 1;
    localparam int BIT_RX_BYPASS = 0;

    // FIFO numbering, equal to the select field code
    localparam logic [1:0] FIFO_RX_ONE = 2'h0;
    localparam logic [1:0] FIFO_RX_TWO = 2'h1;
    localparam logic [1:0] FIFO_TX_ONE = 2'h2;
    localparam logic [1:0] FIFO_TX_TWO = 2'h3;
endpackage

// ==== verification/hdlc_fifo_test_access_tb_top.sv ====
// Self-checking bench for the FIFO test access block.
// Assumes the host model drives the register port; the bench drives the link side.
module hdlc_fifo_test_access_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import hft_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v, w, a;
    logic [1:0] link_clk_enable;
    logic [3:0] host_fifo_wr, fifo_clk_enable, fill_valid, fill_ready, drain_req, drain_valid;
    logic [3:0] fifo_empty, fifo_full, msg_mark;
    logic [3:0][7:0] fill_data, drain_data;
    logic [7:0] q[4][$];
    int rp[4], wp[4], srp[4], swp[4];
    int n_errors, check_count, i, n;
    logic [31:0] seed = 32'hC683;
    always #2.5 ref_clk = ~ref_clk;
    hft_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_fifo_wr(host_fifo_wr));
    hdlc_fifo_test_access dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .host_fifo_wr(host_fifo_wr), .link_clk_enable(link_clk_enable),
        .fifo_clk_enable(fifo_clk_enable), .fill_valid(fill_valid), .fill_data(fill_data),
        .fill_ready(fill_ready), .drain_req(drain_req), .drain_valid(drain_valid),
        .drain_data(drain_data), .fifo_empty(fifo_empty), .fifo_full(fifo_full),
        .msg_mark(msg_mark));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Bypass fills are not stored, so they check the piped word instead
    task automatic fill(input int f, input logic [7:0] d, input logic byp);
        @(negedge ref_clk);
        fill_valid[f] = 1'b1;
        fill_data[f] = d;
        @(negedge ref_clk);
        fill_valid[f] = 1'b0;
        fill_data[f] = ~d;
        if (byp) chk({7'h0, drain_valid[f]}, 8'h01);
        if (byp) chk(drain_data[f], d);
        if (!byp) q[f].push_back(d);
        if (!byp) wp[f] = (wp[f] + 1) % 64;
    endtask
    task automatic drain(input int f);
        @(negedge ref_clk);
        drain_req[f] = 1'b1;
        @(negedge ref_clk);
        drain_req[f] = 1'b0;
        chk({7'h0, drain_valid[f]}, 8'h01);
        chk(drain_data[f], q[f].pop_front());
        rp[f] = (rp[f] + 1) % 64;
    endtask
    task automatic ptrs(input int f, input logic s);
        logic [7:0] r;
        host.wr(ADDR_FIFO_TEST_SELECT, {5'h0, s, 2'(f)});
        host.rd(ADDR_READ_PTR_STATUS, r);
        chk(r, 8'(s ? srp[f] : rp[f]));
        host.rd(ADDR_WRITE_PTR_STATUS, r);
        chk(r, 8'(s ? swp[f] : wp[f]));
    endtask
    initial begin
        #200000;
        n_errors++;
        final_report();
    end
    initial begin
        {rstn, link_clk_enable, fill_valid, drain_req, msg_mark} = '0;
        fill_data = '0;
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (3) @(posedge ref_clk);
        for (int k = 'hBA; k <= 'hBF; k++) begin
            host.rd(8'(k), v);
            chk(v, 8'h00);
            w = 8'(xs());
            host.wr(8'(k), w);
            host.rd(8'(k), v);
            chk(v, k inside {'hBB, 'hBC, 'hBF} ? 8'h00 : w & (k == 'hBA ? 8'h0F : 8'h7F));
        end
        host.quiet();
        for (int k = 0; k < 8; k++) begin
            link_clk_enable = 2'(k);
            host.wr(ADDR_FIFO_TEST_SELECT, {4'h0, k[2], 3'h0});
            chk({4'h0, fifo_clk_enable}, k[2] ? 8'h0F : {4'h0, k[1:0], k[1:0]});
        end
        for (i = 0; i < 4; i++) begin
            n = 1 + int'(xs() % 4);
            repeat (n) fill(i, 8'(xs()), 1'b0);
            drain(i);
            @(negedge ref_clk) msg_mark[i] = 1'b1;
            @(negedge ref_clk) msg_mark[i] = 1'b0;
            srp[i] = rp[i];
            swp[i] = wp[i];
            fill(i, 8'(xs()), 1'b0);
            ptrs(i, 1'b0);
            ptrs(i, 1'b1);
        end
        for (int c = 0; c < 2; c++) begin
            a = c ? ADDR_CH2_TEST_CONTROL : ADDR_CH1_TEST_CONTROL;
            host.wr(a, 8'h12);
            for (int f = c; f < 4; f += 2) begin
                w = 8'(xs());
                host.put(4'(1 << f), w);
                q[f].push_back(w);
                wp[f] = (wp[f] + 1) % 64;
            end
            host.wr(a, 8'h00);
            ptrs(c, 1'b0);
            ptrs(c + 2, 1'b0);
            while (q[c + 2].size() > 1) drain(c + 2);
            host.wr(a, 8'h48);
            host.wr(a, 8'h24);
            for (int f = c; f < 4; f += 2) begin
                rp[f] = wp[f];
                q[f].delete();
                chk({7'h0, fifo_empty[f]}, 8'h01);
                chk({7'h0, fifo_full[f]}, 8'h00);
                chk({7'h0, fill_ready[f]}, 8'h00);
            end
            host.wr(a, 8'h00);
            ptrs(c + 2, 1'b0);
            host.wr(a, 8'h01);
            fill(c, 8'(xs()), 1'b1);
            host.wr(a, 8'h00);
        end
        host.quiet();
        final_report();
    end
endmodule

// ==== verification/hft_host_model.sv ====
// Host processor model on the parallel register port.
// Assumes the block samples strobes at the rising edge of ref_clk.
module hft_host_model (
    input wire logic ref_clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    output logic [3:0] host_fifo_wr
);
    timeunit 1ns;
    timeprecision 100ps;
    import hft_pkg::*;
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        host_fifo_wr = 4'h0;
    end
    // Idle bus shows inverted values so a stale address never looks valid
    task automatic cyc(input logic [1:0] k, input logic [7:0] a, input logic [7:0] d,
        input logic [3:0] f);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = k[0];
        reg_rd = k[1];
        host_fifo_wr = f;
        @(negedge ref_clk);
        reg_addr = ~a;
        reg_wdata = ~d;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        host_fifo_wr = 4'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(2'h1, a, d, 4'h0);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        cyc(2'h2, a, 8'h00, 4'h0);
        v = reg_rdata;
    endtask
    task automatic put(input logic [3:0] f, input logic [7:0] d);
        cyc(2'h0, 8'h00, d, f);
    endtask
    task automatic quiet();
        wr(ADDR_FIFO_TEST_SELECT, 8'h00);
        wr(ADDR_CH1_TEST_CONTROL, 8'h00);
        wr(ADDR_CH2_TEST_CONTROL, 8'h00);
    endtask
endmodule

// ==== verification/hft_props.sv ====
// Checker for the FIFO test access block, bound to its top module.
// Assumes register strobes are one-cycle pulses on ref_clk.
module hft_props #(
    parameter int DW = 8,
    parameter int AW = 6
) (
    input wire logic ref_clk, input wire logic rstn,
    input wire logic [7:0] reg_addr, input wire logic [7:0] reg_wdata,
    input wire logic reg_wr, input wire logic reg_rd, input wire logic [7:0] reg_rdata,
    input wire logic [hft_pkg::NUM_FIFO-1:0] host_fifo_wr, input wire logic [1:0] link_clk_enable,
    input wire logic [hft_pkg::NUM_FIFO-1:0] fifo_clk_enable,
    input wire logic [hft_pkg::NUM_FIFO-1:0] fill_valid,
    input wire logic [hft_pkg::NUM_FIFO-1:0][DW-1:0] fill_data,
    input wire logic [hft_pkg::NUM_FIFO-1:0] fill_ready,
    input wire logic [hft_pkg::NUM_FIFO-1:0] drain_valid,
    input wire logic [hft_pkg::NUM_FIFO-1:0][DW-1:0] drain_data,
    input wire logic [hft_pkg::NUM_FIFO-1:0] fifo_empty,
    input wire logic [hft_pkg::NUM_FIFO-1:0] fifo_full
);
    timeunit 1ns;
    timeprecision 100ps;
    import hft_pkg::*;
    // Own copy of the writable registers, so checks do not lean on the design
    logic [7:0] sel_q, c1_q, c2_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sel_q <= 8'h00;
            c1_q <= 8'h00;
            c2_q <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_FIFO_TEST_SELECT) sel_q <= reg_wdata & MASK_FIFO_TEST_SELECT;
            if (reg_addr == ADDR_CH1_TEST_CONTROL) c1_q <= reg_wdata & MASK_TEST_CONTROL;
            if (reg_addr == ADDR_CH2_TEST_CONTROL) c2_q <= reg_wdata & MASK_TEST_CONTROL;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    AST_CLK_FORCE: assert property (fifo_clk_enable == ({2{link_clk_enable}} | {4{sel_q[3]}}))
        else $error("fifo clock enable wrong");
    AST_SEL_READBACK: assert property (reg_rd && reg_addr == 8'hBA |=> reg_rdata == $past(sel_q))
        else $error("select readback wrong");
    AST_PTR_UPPER: assert property (reg_rd && reg_addr inside {8'hBB, 8'hBC} |=> reg_rdata[7:6] == 2'h0)
        else $error("pointer status upper bits set");
    AST_TX1_READ_CLEAR: assert property (c1_q[6] && !fill_valid[2] && !host_fifo_wr[2] |=> fifo_empty[2])
        else $error("read clear left fifo non-empty");
    AST_TX1_WRITE_CLEAR: assert property (c1_q[5] |-> !fill_ready[2])
        else $error("fill accepted during write clear");
    AST_CH2_READ_CLEAR: assert property (c2_q[3] && !fill_valid[1] && !host_fifo_wr[1] |=> fifo_empty[1])
        else $error("channel two read clear failed");
    AST_TX_TEST_WRITE: assert property (c1_q[4] && host_fifo_wr[2] && !fifo_full[2] && c1_q[6:5] == 2'h0
        |=> !fifo_empty[2])
        else $error("tx test write not stored");
    AST_RX_TEST_WRITE: assert property (c2_q[1] && host_fifo_wr[1] && !fifo_full[1]
        && (c2_q[3:0] & 4'hD) == 4'h0 ##1 1'b1 |-> !fifo_empty[1])
        else $error("rx test write not stored");
    AST_BYPASS_PIPE: assert property (c1_q[0] && fill_valid[0]
        |-> fill_ready[0] ##1 drain_valid[0] && drain_data[0] == $past(fill_data[0]))
        else $error("bypass data not piped");
endmodule

bind hdlc_fifo_test_access hft_props #(.DW(DW), .AW(AW)) u_props (.ref_clk(ref_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .host_fifo_wr(host_fifo_wr), .link_clk_enable(link_clk_enable),
    .fifo_clk_enable(fifo_clk_enable), .fill_valid(fill_valid), .fill_data(fill_data),
    .fill_ready(fill_ready), .drain_valid(drain_valid), .drain_data(drain_data),
    .fifo_empty(fifo_empty), .fifo_full(fifo_full));
